// >>> pkg/mmd_portal_pkg.sv
/*
 * Shared constants, field layouts and state type for the indirect access
 * portal. Assumes a serial management frame on the management clock and
 * data pins, with the portal sitting behind two directly addressed
 * registers of a transceiver.
 */
package mmd_portal_pkg;

   // directly addressed portal registers
   localparam logic [4:0]  REG_CTRL      = 5'h0d;
   localparam logic [4:0]  REG_DATA      = 5'h0e;

   // operation field of the control register
   localparam logic [1:0]  MODE_ADDR     = 2'h0;
   localparam logic [1:0]  MODE_DATA     = 2'h1;
   localparam logic [1:0]  MODE_INC_RW   = 2'h2;
   localparam logic [1:0]  MODE_INC_WR   = 2'h3;

   // management frame op codes and field lengths (counts are last index, except PREAMBLE_ONES, a full count of 32 ones)
   localparam logic [1:0]  FRAME_READ    = 2'h2;
   localparam logic [1:0]  FRAME_WRITE   = 2'h1;
   localparam logic [5:0]  PREAMBLE_ONES = 6'h20;
   localparam logic [5:0]  HDR_LAST      = 6'h0b;
   localparam logic [5:0]  TA_WR_LAST    = 6'h01;
   localparam logic [5:0]  DATA_LAST     = 6'h0f;

   // reset values, address increment step and value read from unbacked words
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;
   localparam logic [15:0] ADDR_STEP     = 16'h0001;
   localparam logic [15:0] READ_ZERO     = 16'h0000;

   // implemented part of the indirect space: low devices, low registers
   localparam int          IMPL_DEV_W    = 2;
   localparam int          IMPL_REG_W    = 5;
   localparam int          IMPL_WORDS    = 1 << (IMPL_DEV_W + IMPL_REG_W);

   typedef struct packed {
      logic [1:0] op;
      logic [8:0] rsvd;
      logic [4:0] dev;
   } ctrl_t;

   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] regad;
   } frame_hdr_t;

   typedef enum logic [2:0] {
      ST_PRE,
      ST_START,
      ST_HDR,
      ST_TA,
      ST_RD,
      ST_WR
   } frame_state_t;

endpackage

// >>> src/mmd_portal.sv
/*
 * Indirect access portal: a management-frame slave exposing a control
 * register and an address/data register that reach a 32 x 64K x 16 bit
 * indirect register space. Assumes the management clock and data pin come
 * from a host outside clk_i's domain and run well below clk_i / 4.
 */
// Notes on behaviour
// - 32 devices, 64K registers, 16-bit words
// - control low five bits hold device address
// - operation 00: data-register write loads address
// - nonzero operation: data register reaches indirect word
// - operation 01: address never moves
// - operation 10: increment after reads and writes
// - operation 11: increment after writes only
// - mode 10 reads return ascending consecutive registers
`timescale 1ns/1ps

module mmd_portal
   import mmd_portal_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic mdc_i,
   input  wire logic mdio_i,
   output logic      mdio_o,
   output logic      mdio_oe_o
);

   logic         mdc_s1, mdc_s2, mdc_d, mdio_s1, mdio_s2;
   logic         rise, bit_in;
   frame_state_t state;
   logic [5:0]   cnt;
   frame_hdr_t   hdr, next_hdr;
   logic         is_read, hit;
   logic [15:0]  wdata, wr_value, rd_shift;
   logic         hdr_done, wr_done, rd_e, wr_e, wr_c;
   ctrl_t        ctrl;
   logic [15:0]  addr;
   logic [15:0]  mem [IMPL_WORDS];
   logic [IMPL_DEV_W+IMPL_REG_W-1:0] cur_idx;
   logic         cur_impl;
   logic [15:0]  cur_word, read_value;
   logic         fresh;

   // the first stage of each synchroniser feeds only the second
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mdc_s1  <= 1'b0;
         mdc_s2  <= 1'b0;
         mdc_d   <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdc_s1  <= mdc_i;
         mdc_s2  <= mdc_s1;
         mdc_d   <= mdc_s2;
         mdio_s1 <= mdio_i;
         mdio_s2 <= mdio_s1;
      end
   end

   assign rise     = mdc_s2 & ~mdc_d;
   assign bit_in   = mdio_s2;
   assign next_hdr = frame_hdr_t'({hdr[10:0], bit_in});
   assign wr_value = {wdata[14:0], bit_in};
   assign hdr_done = rise && state == ST_HDR && cnt == HDR_LAST;
   assign wr_done  = rise && state == ST_WR && cnt == DATA_LAST && hit;
   assign rd_e     = hdr_done && next_hdr.op == FRAME_READ
                     && next_hdr.phy == PHY_ADDR
                     && next_hdr.regad == REG_DATA;
   assign wr_e     = wr_done && hdr.regad == REG_DATA;
   assign wr_c     = wr_done && hdr.regad == REG_CTRL;

   // frames for other addresses are walked through silently, so their
   // data bits never look like a fresh preamble; suppressed preamble is
   // not supported
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state   <= ST_PRE;
         cnt     <= 6'h00;
         hdr     <= '0;
         is_read <= 1'b0;
         hit     <= 1'b0;
         wdata   <= 16'h0000;
      end else if (rise) begin
         case (state)
            ST_PRE: begin
               if (bit_in) begin
                  if (cnt != PREAMBLE_ONES) begin
                     cnt <= 6'(cnt + 6'h01);
                  end
               end else if (cnt == PREAMBLE_ONES) begin
                  state <= ST_START;
               end else begin
                  cnt <= 6'h00;
               end
            end
            ST_START: begin
               cnt   <= 6'h00;
               state <= bit_in ? ST_HDR : ST_PRE;
            end
            ST_HDR: begin
               hdr <= next_hdr;
               cnt <= 6'(cnt + 6'h01);
               if (cnt == HDR_LAST) begin
                  cnt     <= 6'h00;
                  is_read <= next_hdr.op == FRAME_READ;
                  hit     <= next_hdr.phy == PHY_ADDR
                             && (next_hdr.op == FRAME_READ
                                 || next_hdr.op == FRAME_WRITE);
                  state   <= (next_hdr.op == FRAME_READ
                              || next_hdr.op == FRAME_WRITE)
                             ? ST_TA : ST_PRE;
               end
            end
            ST_TA: begin
               cnt <= 6'(cnt + 6'h01);
               if (is_read || cnt == TA_WR_LAST) begin
                  cnt   <= 6'h00;
                  state <= is_read ? ST_RD : ST_WR;
               end
            end
            ST_RD, ST_WR: begin
               wdata <= wr_value;
               cnt   <= 6'(cnt + 6'h01);
               if (cnt == DATA_LAST) begin
                  cnt   <= 6'h00;
                  state <= ST_PRE;
               end
            end
            default: state <= ST_PRE;
         endcase
      end
   end

   // only the low devices and registers are backed by storage
   assign cur_idx  = {ctrl.dev[IMPL_DEV_W-1:0], addr[IMPL_REG_W-1:0]};
   assign cur_impl = ctrl.dev[4:IMPL_DEV_W] == '0
                     && addr[15:IMPL_REG_W] == '0;
   assign cur_word = cur_impl ? mem[cur_idx] : READ_ZERO;

   always_comb begin
      read_value = READ_ZERO;
      if (next_hdr.regad == REG_CTRL) begin
         read_value = ctrl;
      end else if (next_hdr.regad == REG_DATA) begin
         read_value = ctrl.op == MODE_ADDR ? addr : cur_word;
      end
   end

   // turnaround drives a zero, then data msb first, released afterwards
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mdio_o    <= 1'b0;
         mdio_oe_o <= 1'b0;
         rd_shift  <= 16'h0000;
      end else if (rise) begin
         if (hdr_done) begin
            rd_shift <= read_value;
         end
         if (state == ST_TA && is_read && hit) begin
            mdio_oe_o <= 1'b1;
            mdio_o    <= 1'b0;
         end else if (state == ST_RD && hit) begin
            mdio_oe_o <= 1'b1;
            mdio_o    <= rd_shift[15];
            rd_shift  <= {rd_shift[14:0], 1'b0};
         end else begin
            mdio_oe_o <= 1'b0;
            mdio_o    <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl <= ctrl_t'(CTRL_RESET);
      end else if (wr_c) begin
         ctrl <= ctrl_t'(wr_value);
      end
   end

   // the 16-bit add wraps past the top address by itself
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         addr <= ADDR_RESET;
      end else if (wr_e) begin
         if (ctrl.op == MODE_ADDR) begin
            addr <= wr_value;
         end else if (ctrl.op == MODE_INC_RW || ctrl.op == MODE_INC_WR) begin
            addr <= 16'(addr + ADDR_STEP);
         end
      end else if (rd_e && ctrl.op == MODE_INC_RW) begin
         addr <= 16'(addr + ADDR_STEP);
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_e && ctrl.op != MODE_ADDR && cur_impl) begin
         mem[cur_idx] <= wr_value;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_dev_store: assert property (wr_c |=>
      ctrl.dev == $past(wr_value[4:0]))
      else $error("device address not stored");
   a_addr_load: assert property (
      wr_e && ctrl.op == MODE_ADDR |=> addr == $past(wr_value))
      else $error("register address not loaded");
   a_data_write: assert property (
      wr_e && ctrl.op != MODE_ADDR && cur_impl
      |=> mem[$past(cur_idx)] == $past(wr_value))
      else $error("indirect word not written");
   a_read_data: assert property (
      rd_e && ctrl.op != MODE_ADDR
      |=> rd_shift == $past(cur_word))
      else $error("indirect read value wrong");
   a_addr_hold: assert property (
      (rd_e || wr_e) && ctrl.op == MODE_DATA |=> $stable(addr))
      else $error("address moved without increment mode");
   a_incr_rw: assert property (
      (rd_e || wr_e) && ctrl.op == MODE_INC_RW
      |=> addr == 16'($past(addr) + ADDR_STEP))
      else $error("address not incremented");
   a_incr_wr_only: assert property (
      wr_e && ctrl.op == MODE_INC_WR
      |=> addr == 16'($past(addr) + ADDR_STEP))
      else $error("write did not increment");
   a_read_no_step: assert property (
      rd_e && ctrl.op == MODE_INC_WR |=> $stable(addr))
      else $error("read moved address in write-increment mode");
   a_reset_clear: assert property (
      fresh |-> ctrl == ctrl_t'(CTRL_RESET) && addr == ADDR_RESET)
      else $error("state not cleared by reset");
   a_ta_drive: assert property (
      rd_e |-> ##[1:40] (mdio_oe_o && !mdio_o))
      else $error("read turnaround not driven");

endmodule

// >>> verification/mdio_host_model.sv
/*
 * Behavioural management host: drives mdc and mdio for one frame at a time.
 * Assumes the wire level, with its pull-up, is fed back on mdio_i.
 */
`timescale 1ns/1ps

module mdio_host_model
   import mmd_portal_pkg::*;
(
   output logic      mdc_o,
   output logic      mdio_o,
   output logic      mdio_oe_o,
   input  wire logic mdio_i
);
   initial begin
      mdc_o     = 1'b0;
      mdio_o    = 1'b1;
      mdio_oe_o = 1'b0;
   end

   // data changes while mdc is low; the pin is sampled just before the rise
   task automatic bit_cycle(input logic b, input logic drv, output logic s);
      mdc_o     = 1'b0;
      mdio_o    = b;
      mdio_oe_o = drv;
      #24;
      s     = mdio_i;
      mdc_o = 1'b1;
      #24;
   endtask

   // ok reports a zero turnaround bit and a released pin after the data
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] regad, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
      logic [45:0] hdr;
      logic        s;
      hdr = {{32{1'b1}}, 2'b01, op, phy, regad};
      rd  = 16'h0000;
      ok  = 1'b1;
      for (int i = 45; i >= 0; i--) bit_cycle(hdr[i], 1'b1, s);
      if (op == FRAME_READ) begin
         bit_cycle(1'b1, 1'b0, s);
         bit_cycle(1'b1, 1'b0, s);
         ok = (s === 1'b0);
         for (int i = 15; i >= 0; i--) begin
            bit_cycle(1'b1, 1'b0, s);
            rd[i] = s;
         end
      end else begin
         bit_cycle(1'b1, 1'b1, s);
         bit_cycle(1'b0, 1'b1, s);
         for (int i = 15; i >= 0; i--) bit_cycle(wd[i], 1'b1, s);
      end
      // idle cycle lets the commit land and shows the pin released
      bit_cycle(1'b1, 1'b0, s);
      ok = ok & (s === 1'b1);
      mdc_o = 1'b0;
   endtask
endmodule

// >>> verification/mmd_indirect_access_portal_tb_top.sv
/*
 * Self-checking bench for the indirect access portal: a host model runs
 * management frames; expectations come from bench functions.
 * Assumes the portal answers at management address 1.
 */
`timescale 1ns/1ps

module mmd_indirect_access_portal_tb_top;
   import mmd_portal_pkg::*;
   localparam logic [4:0] PHY = 5'h01;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        mdc, host_mdio, host_oe, dut_mdio, dut_oe;
   wire logic   mdio_line;
   int          n_mismatch = 0;
   int          n_checks = 0;
   logic [15:0] d [4];
   logic [15:0] base, rv;
   logic [4:0]  dev;
   logic        ok;

   always #2.5 clk_i = ~clk_i;
   // pull-up: the line floats high when nobody drives it
   assign mdio_line = dut_oe ? dut_mdio : (host_oe ? host_mdio : 1'b1);

   mdio_host_model host (.mdc_o(mdc), .mdio_o(host_mdio),
                         .mdio_oe_o(host_oe), .mdio_i(mdio_line));
   mmd_portal #(.PHY_ADDR(PHY)) dut (.clk_i(clk_i), .reset_i(reset_i),
      .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(dut_mdio),
      .mdio_oe_o(dut_oe));

   function automatic logic [15:0] exp_rd(logic [4:0] dv, logic [15:0] a,
                                          logic [15:0] v);
      return (dv < 5'h04 && a < 16'h0020) ? v : READ_ZERO;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] r, input logic [15:0] v);
      host.frame(FRAME_WRITE, PHY, r, v, rv, ok);
   endtask

   task automatic rd_chk(input logic [4:0] r, input logic [15:0] exp);
      host.frame(FRAME_READ, PHY, r, 16'h0000, rv, ok);
      check(rv, exp);
      check({15'h0000, ok}, 16'h0001);
   endtask

   task automatic sel(input logic [4:0] dv, input logic [15:0] a,
                      input logic [1:0] m);
      wr(REG_CTRL, {MODE_ADDR, 9'h000, dv});
      wr(REG_DATA, a);
      wr(REG_CTRL, {m, 9'h000, dv});
   endtask

   task automatic addr_chk(input logic [4:0] dv, input logic [15:0] exp);
      wr(REG_CTRL, {MODE_ADDR, 9'h000, dv});
      rd_chk(REG_DATA, exp);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // about 87 frames of 65 bits at 48 ns run near 272 us; some slack
   initial begin
      #350000;
      n_mismatch++;
      results();
   end

   initial begin
      void'($urandom(32'h781f4d5d));
      repeat (10) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rd_chk(REG_CTRL, CTRL_RESET);
      rd_chk(REG_DATA, ADDR_RESET);
      d[0] = {MODE_ADDR, 14'($urandom)};
      wr(REG_CTRL, d[0]);
      rd_chk(REG_CTRL, d[0]);
      host.frame(FRAME_WRITE, PHY + 5'h01, REG_CTRL, 16'h0000, rv, ok);
      rd_chk(REG_CTRL, d[0]);
      $display("test reset and control done");
      for (int i = 0; i < 6; i++) begin
         dev  = 5'($urandom % 6);
         base = 16'($urandom % 40);
         d[0] = 16'($urandom);
         sel(dev, base, MODE_DATA);
         wr(REG_DATA, d[0]);
         rd_chk(REG_DATA, exp_rd(dev, base, d[0]));
         rd_chk(REG_DATA, exp_rd(dev, base, d[0]));
         addr_chk(dev, base);
      end
      $display("test single data access done");
      base = 16'h001c;
      sel(5'h03, base, MODE_INC_WR);
      for (int i = 0; i < 4; i++) begin
         d[i] = 16'($urandom);
         wr(REG_DATA, d[i]);
      end
      wr(REG_CTRL, {MODE_INC_WR, 9'h000, 5'h03});
      rd_chk(REG_DATA, READ_ZERO);
      rd_chk(REG_DATA, READ_ZERO);
      addr_chk(5'h03, base + 16'h0004);
      sel(5'h03, base, MODE_INC_RW);
      for (int i = 0; i < 4; i++) rd_chk(REG_DATA, d[i]);
      wr(REG_DATA, 16'($urandom));
      addr_chk(5'h03, base + 16'h0005);
      $display("test increment modes done");
      sel(5'h01, 16'hffff, MODE_INC_RW);
      rd_chk(REG_DATA, READ_ZERO);
      addr_chk(5'h01, 16'h0000);
      sel(5'h1f, 16'h0003, MODE_DATA);
      wr(REG_DATA, 16'h5a5a);
      rd_chk(REG_DATA, READ_ZERO);
      $display("test wrap and unimplemented done");
      results();
   end
endmodule
